//--- rtl/drive_status_word_packer.sv
// module: packs drive conditions into the two-half status word
`timescale 1ns/1ns
module drive_status_word_packer
  import drive_status_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // conditions from the control core
  input drive_cond_t cond,
  // register port
  input reg_req_t regReq,
  output logic [DATA_W-1:0] rdData,
  // status word and start-block request toward the core
  output logic [WORD_W-1:0] statusWord,
  output logic startBlockRequest
);

  // ==========================================================
  // state
  logic [WORD_W-1:0] statusWord_r;
  logic [WORD_W-1:0] statusWord_nxt;
  logic [DATA_W-1:0] control_r;
  logic [DATA_W-1:0] snapHigh_r;
  logic [DATA_W-1:0] rdData_r;
  logic [DATA_W-1:0] rdData_nxt;

  // ==========================================================
  // status word assembly
  always_comb begin
    statusWord_nxt = STATUS_RESET;
    statusWord_nxt[BIT_READY] = cond.readyForStart;
    statusWord_nxt[BIT_RUN_ENABLED] = cond.runPermission;
    statusWord_nxt[BIT_START_SEEN] = cond.startReceived;
    statusWord_nxt[BIT_ZERO_SPEED] = cond.atZeroSpeed;
    statusWord_nxt[BIT_TARGET_REACHED] = cond.targetReachedFlag;
    statusWord_nxt[BIT_LIMITING] = cond.limitActive;
    statusWord_nxt[BIT_WATCHED_OUT] = cond.watchedValueOutOfRange;
    statusWord_nxt[BIT_REVERSE_REF] = cond.reverseReference;
    statusWord_nxt[BIT_REVERSE_RUN] = cond.reverseRunningFlag;
    statusWord_nxt[BIT_PANEL_LOCAL] = cond.panelLocal;
    statusWord_nxt[BIT_FIELDBUS_LOCAL] = cond.fieldbusLocal;
    statusWord_nxt[BIT_SECOND_PLACE] = cond.secondExternalPlaceActive;
    statusWord_nxt[BIT_FAULT] = cond.faultState;
    statusWord_nxt[BIT_ALARM] = cond.alarmActive;
    statusWord_nxt[BIT_MAINTENANCE] = cond.maintenancePendingFlag;
    statusWord_nxt[BIT_DIR_LOCKED] = cond.directionChangeLocked;
    statusWord_nxt[BIT_LOCAL_LOCKED] = cond.localControlLocked;
    // only scalar control exists here, so the method flag stays low
    statusWord_nxt[BIT_CONTROL_METHOD] = 1'b0;
    statusWord_nxt[BIT_PREHEATING] = cond.preheatingActiveFlag;
    statusWord_nxt[BIT_CMD_WANTED] = cond.commandWordWanted;
    statusWord_nxt[BIT_REF1_WANTED] = cond.firstReferenceWanted;
    statusWord_nxt[BIT_REF2_WANTED] = cond.secondReferenceWanted;
    statusWord_nxt[BIT_PROC_REF_WANTED] = cond.processReferenceWanted;
    // acknowledge only an inhibit that the master asked for and the core applies
    statusWord_nxt[BIT_START_BLOCK_ACK] =
      control_r[CTL_START_BLOCK_REQ] & cond.startBlockApplied;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      statusWord_r <= STATUS_RESET;
    end else begin
      statusWord_r <= statusWord_nxt;
    end
  end

  // ==========================================================
  // control register: start-block request bit 0 copy from the master
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      control_r <= CONTROL_RESET;
    end else if (regReq.wrStb && regReq.addr == OFS_CONTROL) begin
      control_r <= HALF_RESET;
      control_r[CTL_START_BLOCK_REQ] <= regReq.wrData[CTL_START_BLOCK_REQ];
    end
  end

  // ==========================================================
  // coherent pair: a low-half read freezes the high half so that
  // a following snapshot read matches; live reads stay available
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      snapHigh_r <= HALF_RESET;
    end else if (regReq.rdStb && regReq.addr == OFS_STATUS_LOW) begin
      snapHigh_r <= statusWord_r[WORD_W-1:DATA_W];
    end
  end

  // ==========================================================
  // read mux; status halves ignore writes
  always_comb begin
    rdData_nxt = READ_IDLE;
    if (regReq.rdStb) begin
      case (regReq.addr)
        OFS_STATUS_LOW: rdData_nxt = statusWord_r[DATA_W-1:0];
        OFS_STATUS_HIGH: rdData_nxt = statusWord_r[WORD_W-1:DATA_W];
        OFS_CONTROL: rdData_nxt = control_r;
        OFS_SNAP_HIGH: rdData_nxt = snapHigh_r;
        default: rdData_nxt = READ_IDLE;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData_r <= READ_IDLE;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign rdData = rdData_r;
  assign statusWord = statusWord_r;
  assign startBlockRequest = control_r[CTL_START_BLOCK_REQ];

endmodule : drive_status_word_packer

//--- rtl/drive_status_pkg.sv
// package: drive status word layout, register map and condition carrier
package drive_status_pkg;

  // ==========================================================
  // register map (word offsets on the plain register port)
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STATUS_LOW = 4'h0;
  localparam logic [3:0] OFS_STATUS_HIGH = 4'h1;
  localparam logic [3:0] OFS_CONTROL = 4'h2;
  localparam logic [3:0] OFS_SNAP_HIGH = 4'h3;

  localparam int DATA_W = 16;
  localparam int WORD_W = 32;

  // ==========================================================
  // reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  // ==========================================================
  // control register field
  localparam int CTL_START_BLOCK_REQ = 0;

  // ==========================================================
  // status word bit positions
  localparam int BIT_READY = 0;
  localparam int BIT_RUN_ENABLED = 1;
  localparam int BIT_START_SEEN = 2;
  localparam int BIT_ZERO_SPEED = 4;
  localparam int BIT_TARGET_REACHED = 7;
  localparam int BIT_LIMITING = 8;
  localparam int BIT_WATCHED_OUT = 9;
  localparam int BIT_REVERSE_REF = 10;
  localparam int BIT_REVERSE_RUN = 11;
  localparam int BIT_PANEL_LOCAL = 12;
  localparam int BIT_FIELDBUS_LOCAL = 13;
  localparam int BIT_SECOND_PLACE = 14;
  localparam int BIT_FAULT = 15;
  localparam int BIT_ALARM = 16;
  localparam int BIT_MAINTENANCE = 17;
  localparam int BIT_DIR_LOCKED = 18;
  localparam int BIT_LOCAL_LOCKED = 19;
  localparam int BIT_CONTROL_METHOD = 20;
  localparam int BIT_PREHEATING = 22;
  localparam int BIT_CMD_WANTED = 26;
  localparam int BIT_REF1_WANTED = 27;
  localparam int BIT_REF2_WANTED = 28;
  localparam int BIT_PROC_REF_WANTED = 29;
  localparam int BIT_START_BLOCK_ACK = 30;

  // ==========================================================
  // condition flags from the control core
  typedef struct packed {
    logic readyForStart;
    logic runPermission;
    logic startReceived;
    logic atZeroSpeed;
    logic targetReachedFlag;
    logic limitActive;
    logic watchedValueOutOfRange;
    logic reverseReference;
    logic reverseRunningFlag;
    logic panelLocal;
    logic fieldbusLocal;
    logic secondExternalPlaceActive;
    logic faultState;
    logic alarmActive;
    logic maintenancePendingFlag;
    logic directionChangeLocked;
    logic localControlLocked;
    logic preheatingActiveFlag;
    logic commandWordWanted;
    logic firstReferenceWanted;
    logic secondReferenceWanted;
    logic processReferenceWanted;
    logic startBlockApplied;
  } drive_cond_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrStb;
    logic rdStb;
  } reg_req_t;

endpackage : drive_status_pkg

//--- verif/drive_status_monitor.sv
// checker: status word and register port relations over time
`timescale 1ns/1ns
module drive_status_monitor
  import drive_status_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // watched ports
  input drive_cond_t cond,
  input reg_req_t regReq,
  input logic [DATA_W-1:0] rdData,
  input logic [WORD_W-1:0] statusWord,
  input logic startBlockRequest
);
  // ====
  // steps
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_live; !$past(srst); endsequence
  sequence s_ctl_wr; regReq.wrStb && regReq.addr == OFS_CONTROL; endsequence
  sequence s_low_rd; $past(regReq.rdStb && regReq.addr == OFS_STATUS_LOW); endsequence
  a_ready_bit: assert property (s_live |-> statusWord[0] == $past(cond.readyForStart))
    else $error("ready bit wrong");
  a_fault_bit: assert property (s_live |-> statusWord[15] == $past(cond.faultState))
    else $error("fault bit wrong");
  a_reserved_zero: assert property ((statusWord & 32'h83A0_0000) == 32'h0000_0000)
    else $error("reserved bit set");
  a_method_zero: assert property (statusWord[20] == 1'b0)
    else $error("control method bit set");
  a_read_idle: assert property (s_live and !$past(regReq.rdStb) |-> rdData == 16'h0000)
    else $error("read data outside read cycle");
  a_low_read: assert property (
    s_low_rd and $stable(statusWord) |-> rdData == statusWord[15:0])
    else $error("low half read wrong");
  a_ctl_write: assert property (s_ctl_wr |=> startBlockRequest == $past(regReq.wrData[0]))
    else $error("control write lost");
  a_status_ro: assert property (
    regReq.wrStb && regReq.addr != OFS_CONTROL |=> $stable(startBlockRequest))
    else $error("write to read-only place took effect");
  a_block_ack: assert property (
    s_live |-> statusWord[30] == $past(startBlockRequest && cond.startBlockApplied))
    else $error("start block acknowledge wrong");
endmodule : drive_status_monitor

//--- verif/fb_master_model.sv
// model: fieldbus master issuing one-cycle register strobes
`timescale 1ns/1ns
module fb_master_model
  import drive_status_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // register port request
  output reg_req_t regReq
);
  initial regReq = '0;
  // idle lines carry the inverse so a stale value never looks valid
  task automatic xfer(input logic [3:0] a, input logic [15:0] d, input logic wr);
    @(posedge clk_sys);
    regReq <= '{addr: a, wrData: d, wrStb: wr, rdStb: !wr};
    @(posedge clk_sys);
    regReq <= '{addr: ~a, wrData: ~d, wrStb: 1'b0, rdStb: 1'b0};
  endtask : xfer
endmodule : fb_master_model

//--- verif/testbench.sv
// testbench: random drive conditions, register reads and control writes
`timescale 1ns/1ns
module testbench
  import drive_status_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  drive_cond_t cond = '0;
  reg_req_t regReq;
  logic [DATA_W-1:0] rdData;
  logic [WORD_W-1:0] statusWord;
  logic startBlockRequest;
  logic rdLate = 1'b0;
  logic ctl;
  logic [31:0] ew;
  logic [15:0] q[$];
  int seed = 32'h3e9b;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clk_sys = ~clk_sys;
  drive_status_word_packer i_dut (.clk_sys(clk_sys), .srst(srst), .cond(cond), .regReq(regReq),
    .rdData(rdData), .statusWord(statusWord), .startBlockRequest(startBlockRequest));
  fb_master_model i_master (.clk_sys(clk_sys), .regReq(regReq));
  // ====
  // checking
  task automatic print_verdict;
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [31:0] expw(input drive_cond_t c, input logic k);
    int pos[22] = '{0, 1, 2, 4, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 22,
      26, 27, 28, 29};
    logic [22:0] v;
    v = c;
    expw = 32'h0000_0000;
    for (int i = 0; i < 22; i++) expw[pos[i]] = v[22-i];
    expw[30] = k & c.startBlockApplied;
  endfunction : expw
  always @(posedge clk_sys) rdLate <= regReq.rdStb;
  always @(negedge clk_sys) begin
    if (rdLate) cmp({16'h0000, rdData}, {16'h0000, q.pop_front()});
  end
  // long enough for all loops with margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      cond <= drive_cond_t'(23'($random(seed)));
      ctl = 1'($random(seed));
      i_master.xfer(OFS_CONTROL, {15'h0000, ctl}, 1'b1);
      i_master.xfer(OFS_STATUS_HIGH, 16'hffff, 1'b1);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      ew = expw(cond, ctl);
      cmp(statusWord, ew);
      q.push_back(ew[15:0]);
      i_master.xfer(OFS_STATUS_LOW, 16'h0000, 1'b0);
      q.push_back(ew[31:16]);
      i_master.xfer(OFS_STATUS_HIGH, 16'h0000, 1'b0);
      q.push_back(ew[31:16]);
      i_master.xfer(OFS_SNAP_HIGH, 16'h0000, 1'b0);
      q.push_back({15'h0000, ctl});
      i_master.xfer(OFS_CONTROL, 16'h0000, 1'b0);
      q.push_back(16'h0000);
      i_master.xfer(4'h4 | 4'($random(seed)), 16'h0000, 1'b0);
    end
    repeat (3) @(posedge clk_sys);
    print_verdict();
  end
endmodule : testbench
bind drive_status_word_packer drive_status_monitor i_mon (.clk_sys(clk_sys), .srst(srst),
  .cond(cond), .regReq(regReq), .rdData(rdData), .statusWord(statusWord),
  .startBlockRequest(startBlockRequest));
